// file: hdl/ccc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccc_regs.svh"
module ccc_core #(
  parameter bit P_TWO_CH = 1'b1,
  parameter logic [31:0] P_CONV_LONG_CYC =
    32'(`CCC_CONV_LONG_MS * 1000 * `CCC_CLK_MHZ),
  parameter logic [31:0] P_CONV_SHORT_CYC =
    32'(`CCC_CONV_SHORT_MS * 1000 * `CCC_CLK_MHZ),
  parameter logic [31:0] P_PERIOD0_CYC =
    32'(64'(`CCC_PERIOD0_S) * 64'd1000000 * 64'(`CCC_CLK_MHZ))
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_ptr,
  input wire logic [7:0] i_wdata,
  input wire logic i_gc_addr_stb,
  input wire logic i_gc_stb,
  input wire logic [7:0] i_gc_byte,
  input wire logic i_det_diode,
  input wire logic [2:0] i_det_range,
  output logic [7:0] o_rdata,
  output logic o_gc_ack,
  output logic o_shutdown,
  output logic o_conv_start,
  output logic o_conv_end,
  output logic o_conv_abort,
  output logic [1:0] o_conv_chan,
  output logic o_beta_auto,
  output logic [2:0] o_beta_range,
  output logic [18:0] o_eta_num,
  output logic [8:0] o_eta_den,
  output logic o_alarm_release
);
  import ccc_pkg::*;

  ccc_state_t s;
  ccc_state_t n;
  logic [2:0] ch_en;

  ////////////////////////////////////////////////////////////
  // Helpers

  function automatic ccc_state_t rst_state();
    ccc_state_t r;
    r = '0;
    r.fsm = CCC_IDLE;
    r.cfg1 = `CCC_CFG1_RST;
    r.cfg2 = P_TWO_CH ? `CCC_CFG2_RST_TWO : `CCC_CFG2_RST_ONE;
    r.rate = `CCC_RATE_RST;
    r.adj1 = `CCC_ADJ_RST;
    r.adj2 = `CCC_ADJ_RST;
    r.beta1 = `CCC_BETA_RST;
    r.beta2 = `CCC_BETA_RST;
    r.res1 = `CCC_BETA_RST;
    r.res2 = `CCC_BETA_RST;
    r.eta_num = `CCC_ETA_NUM_1008;
    r.eta_den = 9'(`CCC_ETA_K);
    return r;
  endfunction

  // Next enabled channel at or after the given one
  function automatic logic [2:0] first_en(
    input logic [2:0] from,
    input logic [2:0] en
  );
    logic [2:0] r;
    r = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // Signed adjust folded into the denominator
  function automatic logic [8:0] eta_den_of(input logic [7:0] adj);
    logic [9:0] t;
    t = `CCC_ETA_K - {{2{adj[7]}}, adj};
    return t[8:0];
  endfunction

  function automatic logic [31:0] period_of(input logic [7:0] code);
    logic [7:0] c;
    c = (code > `CCC_RATE_MAX) ? `CCC_RATE_MAX : code;
    return P_PERIOD0_CYC >> c;
  endfunction

  function automatic logic [3:0] beta_rd(
    input logic [3:0] cfg,
    input logic [3:0] res
  );
    return cfg[3] ? res : cfg;
  endfunction

  // Start a channel, or close the pass when none is left
  function automatic ccc_state_t launch(
    input ccc_state_t x,
    input logic [2:0] f
  );
    ccc_state_t y;
    logic [3:0] c;
    logic [7:0] adj;
    y = x;
    c = (f[1:0] == 2'd2) ? x.beta2 : x.beta1;
    adj = (f[1:0] == 2'd2) ? x.adj2 : x.adj1;
    if (!f[2]) begin
      if (x.one_shot) begin
        y.fsm = CCC_SHUT;
        y.one_shot = 1'b0;
      end else begin
        y.fsm = CCC_IDLE;
      end
    end else begin
      y.fsm = CCC_CONV;
      y.chan = f[1:0];
      y.start = 1'b1;
      y.conv_cnt = P_CONV_SHORT_CYC;
      y.b_auto = 1'b0;
      y.b_range = 3'h0;
      y.eta_num = `CCC_ETA_NUM_1008;
      y.eta_den = eta_den_of(adj);
      if (f[1:0] != 2'd0) begin
        if (c[3] && !i_det_diode) begin
          y.b_auto = 1'b1;
          y.b_range = i_det_range;
          y.eta_num = `CCC_ETA_NUM_1000;
          y.conv_cnt = P_CONV_LONG_CYC;
        end else if (c[3]) begin
          y.b_range = 3'h7;
        end else if (c != `CCC_BETA_OFF) begin
          y.b_range = c[2:0];
          y.eta_num = `CCC_ETA_NUM_1000;
        end
        if (c[3]) begin
          if (f[1:0] == 2'd2) begin
            y.res2 = i_det_diode ? `CCC_BETA_DIODE : {1'b1, i_det_range};
          end else begin
            y.res1 = i_det_diode ? `CCC_BETA_DIODE : {1'b1, i_det_range};
          end
        end
      end
    end
    return y;
  endfunction

  // Begin a pass and restart the rate period
  function automatic ccc_state_t pass(input ccc_state_t x);
    ccc_state_t y;
    y = x;
    y.per_cnt = period_of(x.rate) - 32'h1;
    return launch(y, first_en(3'h0, ch_en));
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    logic [7:0] r;
    r = 8'h00;
    if (p == `CCC_PTR_CFG1_RD) begin
      r = s.cfg1;
    end else if (p == `CCC_PTR_RATE_RD) begin
      r = s.rate;
    end else if (!P_TWO_CH && p == `CCC_PTR_CFG2_ONE) begin
      r = s.cfg2;
    end else if (P_TWO_CH && p == `CCC_PTR_CFG2_TWO) begin
      r = s.cfg2;
    end else if (!P_TWO_CH && p == `CCC_PTR_ADJ_ONE) begin
      r = s.adj1;
    end else if (P_TWO_CH && p == `CCC_PTR_ADJ_R1) begin
      r = s.adj1;
    end else if (P_TWO_CH && p == `CCC_PTR_ADJ_R2) begin
      r = s.adj2;
    end else if (p == `CCC_PTR_BETA_R1) begin
      r = {4'h0, beta_rd(s.beta1, s.res1)};
    end else if (P_TWO_CH && p == `CCC_PTR_BETA_R2) begin
      r = {4'h0, beta_rd(s.beta2, s.res2)};
    end
    return r;
  endfunction

  assign ch_en = {s.cfg2[5] & P_TWO_CH, s.cfg2[4], s.cfg2[3]};

  ////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    n.start = 1'b0;
    n.done = 1'b0;
    n.abort = 1'b0;
    n.rel = 1'b0;
    n.gc_ack = i_gc_addr_stb;
    if (i_rd_stb) begin
      n.rdata = rd_mux(i_ptr);
    end
    if (s.fsm != CCC_SHUT && s.per_cnt != 32'h0) begin
      n.per_cnt = s.per_cnt - 32'h1;
    end

    unique case (s.fsm)
      CCC_SHUT: begin
        if (!s.cfg1[`CCC_CFG1_SD_BIT]) begin
          n.fsm = CCC_IDLE;
          n.per_cnt = 32'h0;
        end
      end
      CCC_IDLE: begin
        if (s.cfg1[`CCC_CFG1_SD_BIT]) begin
          n.fsm = CCC_SHUT;
        end else if (s.per_cnt == 32'h0) begin
          n = pass(n);
        end
      end
      CCC_CONV: begin
        if (s.conv_cnt > 32'h1) begin
          n.conv_cnt = s.conv_cnt - 32'h1;
        end else begin
          n.done = 1'b1;
          n.conv_cnt = 32'h0;
          n = launch(n, first_en(3'(s.chan) + 3'h1, ch_en));
        end
      end
    endcase

    if (i_wr_stb) begin
      if (i_ptr == `CCC_PTR_CFG1_WR) begin
        n.cfg1 = i_wdata & `CCC_CFG1_MASK;
        if (i_wdata[`CCC_CFG1_SD_BIT] && n.fsm != CCC_SHUT) begin
          n.fsm = CCC_SHUT;
          n.abort = (s.fsm == CCC_CONV);
          n.start = 1'b0;
          n.done = 1'b0;
          n.one_shot = 1'b0;
          n.conv_cnt = 32'h0;
        end
      end else if (i_ptr == `CCC_PTR_RATE_WR) begin
        n.rate = i_wdata;
      end else if (!P_TWO_CH && i_ptr == `CCC_PTR_CFG2_ONE) begin
        n.cfg2 = i_wdata & `CCC_CFG2_MASK;
      end else if (P_TWO_CH && i_ptr == `CCC_PTR_CFG2_TWO) begin
        n.cfg2 = i_wdata & `CCC_CFG2_MASK;
      end else if (!P_TWO_CH && i_ptr == `CCC_PTR_ADJ_ONE) begin
        n.adj1 = i_wdata;
      end else if (P_TWO_CH && i_ptr == `CCC_PTR_ADJ_R1) begin
        n.adj1 = i_wdata;
      end else if (P_TWO_CH && i_ptr == `CCC_PTR_ADJ_R2) begin
        n.adj2 = i_wdata;
      end else if (i_ptr == `CCC_PTR_BETA_R1) begin
        n.beta1 = i_wdata[3:0];
        n.res1 = `CCC_BETA_RST;
      end else if (P_TWO_CH && i_ptr == `CCC_PTR_BETA_R2) begin
        n.beta2 = i_wdata[3:0];
        n.res2 = `CCC_BETA_RST;
      end else if (i_ptr == `CCC_PTR_SHOT) begin
        // Data byte is not kept
        if (s.cfg1[`CCC_CFG1_SD_BIT] && s.fsm == CCC_SHUT) begin
          n.one_shot = 1'b1;
          n = pass(n);
        end
      end
    end

    if ((i_wr_stb && i_ptr == `CCC_PTR_SRST) ||
        (i_gc_stb && i_gc_byte == `CCC_GC_RESET_CODE)) begin
      n = rst_state();
      n.abort = (s.fsm == CCC_CONV);
      n.rel = 1'b1;
      n.gc_ack = i_gc_addr_stb;
    end
  end

  ////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= rst_state();
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs

  assign o_rdata = s.rdata;
  assign o_gc_ack = s.gc_ack;
  assign o_shutdown = s.cfg1[`CCC_CFG1_SD_BIT];
  assign o_conv_start = s.start;
  assign o_conv_end = s.done;
  assign o_conv_abort = s.abort;
  assign o_conv_chan = s.chan;
  assign o_beta_auto = s.b_auto;
  assign o_beta_range = s.b_range;
  assign o_eta_num = s.eta_num;
  assign o_eta_den = s.eta_den;
  assign o_alarm_release = s.rel;
endmodule
`default_nettype wire

// file: hdl/ccc_pkg.sv
package ccc_pkg;
  typedef enum logic [1:0] {
    CCC_SHUT = 2'b00,
    CCC_CONV = 2'b01,
    CCC_IDLE = 2'b10
  } ccc_fsm_t;

  typedef struct packed {
    ccc_fsm_t fsm;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] rate;
    logic [7:0] adj1;
    logic [7:0] adj2;
    logic [3:0] beta1;
    logic [3:0] beta2;
    logic [3:0] res1;
    logic [3:0] res2;
    logic one_shot;
    logic [1:0] chan;
    logic [31:0] conv_cnt;
    logic [31:0] per_cnt;
    logic [7:0] rdata;
    logic start;
    logic done;
    logic abort;
    logic rel;
    logic gc_ack;
    logic b_auto;
    logic [2:0] b_range;
    logic [18:0] eta_num;
    logic [8:0] eta_den;
  } ccc_state_t;
endpackage

// file: hdl/ccc_regs.svh
`ifndef CCC_REGS_SVH
`define CCC_REGS_SVH
`define CCC_PTR_CFG1_RD 8'h03
`define CCC_PTR_RATE_RD 8'h04
`define CCC_PTR_CFG1_WR 8'h09
`define CCC_PTR_RATE_WR 8'h0A
`define CCC_PTR_SHOT 8'h0F
`define CCC_PTR_ADJ_ONE 8'h18
`define CCC_PTR_CFG2_ONE 8'h1A
`define CCC_PTR_ADJ_R1 8'h27
`define CCC_PTR_ADJ_R2 8'h28
`define CCC_PTR_BETA_R1 8'h35
`define CCC_PTR_BETA_R2 8'h36
`define CCC_PTR_CFG2_TWO 8'h3F
`define CCC_PTR_SRST 8'hFC
`define CCC_GC_RESET_CODE 8'h06
`define CCC_CFG1_RST 8'h00
`define CCC_CFG1_MASK 8'hE4
`define CCC_CFG1_SD_BIT 6
`define CCC_CFG2_RST_ONE 8'h1C
`define CCC_CFG2_RST_TWO 8'h3C
`define CCC_CFG2_MASK 8'h3C
`define CCC_RATE_RST 8'h07
`define CCC_RATE_MAX 8'h06
`define CCC_ADJ_RST 8'h00
`define CCC_BETA_RST 4'h8
`define CCC_BETA_OFF 4'h7
`define CCC_BETA_DIODE 4'hF
`define CCC_ETA_NUM_1008 19'h49D40
`define CCC_ETA_NUM_1000 19'h493E0
`define CCC_ETA_K 10'h12C
`define CCC_CLK_MHZ 125
`define CCC_CONV_LONG_MS 126
`define CCC_CONV_SHORT_MS 93
`define CCC_PERIOD0_S 16
`endif

// file: hdl/ccc_sizes_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/ccc_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ccc_core_props #(
  parameter logic [31:0] P_CONV_LONG_CYC = 32'h14,
  parameter logic [31:0] P_CONV_SHORT_CYC = 32'h0A
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_ptr,
  input wire logic [7:0] i_wdata,
  input wire logic i_gc_addr_stb,
  input wire logic i_gc_stb,
  input wire logic [7:0] i_gc_byte,
  input wire logic [7:0] o_rdata,
  input wire logic o_gc_ack,
  input wire logic o_shutdown,
  input wire logic o_conv_start,
  input wire logic o_conv_end,
  input wire logic [1:0] o_conv_chan,
  input wire logic o_beta_auto,
  input wire logic [2:0] o_beta_range,
  input wire logic [18:0] o_eta_num,
  input wire logic o_alarm_release
);
  logic [31:0] run_cnt;
  logic is_long;
  logic long_q;
  assign is_long = (o_conv_chan != 2'h0) && o_beta_auto && (o_eta_num == 19'h493E0);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_cnt <= 32'h0;
      long_q <= 1'b0;
    end else if (o_conv_start) begin
      run_cnt <= 32'h1;
      long_q <= is_long;
    end else begin
      run_cnt <= run_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  property p_gc_ack;
    i_gc_addr_stb |=> o_gc_ack;
  endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("general call not acknowledged");
  property p_gc_other;
    i_gc_stb && i_gc_byte != 8'h06 && !(i_wr_stb && i_ptr == 8'hFC) |=> !o_alarm_release;
  endproperty
  a_gc_other: assert property (p_gc_other) else $error("reset on wrong code");
  property p_srst;
    (i_wr_stb && i_ptr == 8'hFC) || (i_gc_stb && i_gc_byte == 8'h06) |=> o_alarm_release;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset missed");
  property p_sd;
    i_wr_stb && i_ptr == 8'h09 && !i_gc_stb |=> o_shutdown == $past(i_wdata[6]);
  endproperty
  a_sd: assert property (p_sd) else $error("shutdown bit wrong");
  property p_sd_stop;
    i_wr_stb && i_ptr == 8'h09 && i_wdata[6] && !i_gc_stb |=> !o_conv_end [*4];
  endproperty
  a_sd_stop: assert property (p_sd_stop) else $error("conversion kept after shutdown");
  property p_len;
    o_conv_end |-> run_cnt == (long_q ? P_CONV_LONG_CYC : P_CONV_SHORT_CYC);
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_eta;
    o_conv_start && o_beta_auto && o_beta_range != 3'h7 |-> o_eta_num == 19'h493E0;
  endproperty
  a_eta: assert property (p_eta) else $error("ideality base wrong");
  property p_order;
    o_conv_end && o_conv_start |-> o_conv_chan > $past(o_conv_chan);
  endproperty
  a_order: assert property (p_order) else $error("channel order wrong");
  property p_rd_wo;
    i_rd_stb && (i_ptr == 8'h0F || i_ptr == 8'hFC) |=> o_rdata == 8'h00;
  endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("trigger data readable");
  property p_shot_end;
    o_shutdown && o_conv_end && !o_conv_start && !i_wr_stb |=> !o_conv_start;
  endproperty
  a_shot_end: assert property (p_shot_end) else $error("one-shot kept running");
  c_long: cover property (o_conv_end && is_long);
  c_shot: cover property (o_shutdown && o_conv_start);
  c_rel: cover property (o_alarm_release);
endmodule
`default_nettype wire

// file: test/ccc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ccc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_ptr,
  output logic [7:0] o_wdata,
  output logic o_gc_addr_stb,
  output logic o_gc_stb,
  output logic [7:0] o_gc_byte
);
  initial begin
    {o_wr_stb, o_rd_stb, o_gc_addr_stb, o_gc_stb} = 4'h0;
    {o_ptr, o_wdata, o_gc_byte} = 24'h0;
  end
  // Lines not in use show the inverse of their last value
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    {o_ptr, o_wdata, o_wr_stb} = {p, d, 1'b1};
    @(posedge i_clk);
    #1;
    {o_ptr, o_wdata, o_wr_stb} = {~p, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    {o_ptr, o_rd_stb} = {p, 1'b1};
    @(posedge i_clk);
    #1;
    {o_ptr, o_rd_stb} = {~p, 1'b0};
    d = i_rdata;
  endtask
  // Address byte first, then the second byte
  task automatic gc(input logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_gc_addr_stb = 1'b1;
    @(posedge i_clk);
    #1;
    {o_gc_addr_stb, o_gc_stb, o_gc_byte} = {1'b0, 1'b1, b};
    @(posedge i_clk);
    #1;
    {o_gc_stb, o_gc_byte} = {1'b0, ~b};
  endtask
endmodule
`default_nettype wire

// file: test/conversion_control_and_correction_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module conversion_control_and_correction_tb;
  logic i_clk, i_rst_b, i_wr_stb, i_rd_stb, i_gc_addr_stb, i_gc_stb, i_det_diode;
  logic [7:0] i_ptr, i_wdata, i_gc_byte, o_rdata, d;
  logic [2:0] i_det_range, o_beta_range;
  logic o_gc_ack, o_shutdown, o_conv_start, o_conv_end, o_conv_abort, o_beta_auto;
  logic o_alarm_release;
  logic [1:0] o_conv_chan;
  logic [18:0] o_eta_num;
  logic [8:0] o_eta_den;
  int error_cnt = 0, checks_done = 0, cycle_cnt = 0, n, k;
  logic [31:0] rows [9] = '{32'h0000_0407, 32'h0000_2700, 32'h0000_2800, 32'h1811_1800,
    32'h0A05_0405, 32'h0000_0A00, 32'h2780_2780, 32'h287F_287F, 32'h0FAA_0F00};
  ccc_core #(.P_CONV_LONG_CYC(32'h14), .P_CONV_SHORT_CYC(32'h0A), .P_PERIOD0_CYC(32'h1000))
    u_ccc_core (.i_clk, .i_rst_b, .i_wr_stb, .i_rd_stb, .i_ptr, .i_wdata, .i_gc_addr_stb,
    .i_gc_stb, .i_gc_byte, .i_det_diode, .i_det_range, .o_rdata, .o_gc_ack, .o_shutdown,
    .o_conv_start, .o_conv_end, .o_conv_abort, .o_conv_chan, .o_beta_auto, .o_beta_range,
    .o_eta_num, .o_eta_den, .o_alarm_release);
  ccc_host u_ccc_host (.i_clk, .i_rdata(o_rdata), .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb),
    .o_ptr(i_ptr), .o_wdata(i_wdata), .o_gc_addr_stb(i_gc_addr_stb), .o_gc_stb(i_gc_stb),
    .o_gc_byte(i_gc_byte));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      $display("ERROR %0t: run too long", $time);
      print_verdict();
    end
  end
  task automatic wait_chan(input logic [1:0] c, output int m);
    logic hit;
    hit = 1'b0;
    m = 0;
    while (!hit && m < 2000) begin
      @(posedge i_clk);
      #1;
      m++;
      hit = (o_conv_start === 1'b1 && o_conv_chan === c);
    end
    `CHK(hit, 1'b1)
  endtask
  initial begin
    {i_rst_b, i_det_diode, i_det_range} = 5'h05;
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    foreach (rows[i]) begin
      if (rows[i][31:24] != 8'h00) u_ccc_host.wr(rows[i][31:24], rows[i][23:16]);
      u_ccc_host.rd(rows[i][15:8], d);
      `CHK(d, rows[i][7:0])
    end
    wait_chan(2'h0, n);
    wait_chan(2'h0, n);
    `CHK(n, 128)
    wait_chan(2'h1, n);
    `CHK(o_eta_den, 9'h1AC)
    `CHK(o_eta_num, 19'h493E0)
    `CHK(o_beta_auto, 1'b1)
    wait_chan(2'h2, n);
    `CHK(o_eta_den, 9'h0AD)
    wait_chan(2'h0, n);
    u_ccc_host.rd(8'h35, d);
    `CHK(d, 8'h0D)
    i_det_diode = 1'b1;
    wait_chan(2'h1, n);
    `CHK(o_eta_num, 19'h49D40)
    `CHK(o_beta_range, 3'h7)
    wait_chan(2'h0, n);
    u_ccc_host.rd(8'h35, d);
    `CHK(d, 8'h0F)
    u_ccc_host.wr(8'h35, 8'h07);
    u_ccc_host.wr(8'h36, 8'h03);
    wait_chan(2'h1, n);
    `CHK({o_beta_auto, o_eta_num}, {1'b0, 19'h49D40})
    wait_chan(2'h2, n);
    `CHK({o_beta_range, o_eta_num}, {3'h3, 19'h493E0})
    u_ccc_host.rd(8'h36, d);
    `CHK(d, 8'h03)
    wait_chan(2'h1, n);
    u_ccc_host.wr(8'h09, 8'h40);
    `CHK({o_conv_abort, o_shutdown}, 2'h3)
    repeat (10) @(posedge i_clk);
    u_ccc_host.wr(8'h0F, 8'h55);
    `CHK({o_conv_start, o_conv_chan}, 3'h4)
    k = 0;
    repeat (200) begin
      @(posedge i_clk);
      #1;
      if (o_conv_start === 1'b1) k++;
    end
    `CHK(k, 2)
    `CHK(o_shutdown, 1'b1)
    u_ccc_host.rd(8'h04, d);
    `CHK(d, 8'h05)
    u_ccc_host.wr(8'h09, 8'h00);
    wait_chan(2'h0, n);
    `CHK(o_shutdown, 1'b0)
    wait_chan(2'h1, n);
    u_ccc_host.wr(8'hFC, 8'h00);
    `CHK({o_alarm_release, o_conv_abort}, 2'h3)
    u_ccc_host.rd(8'h04, d);
    `CHK(d, 8'h07)
    u_ccc_host.rd(8'h27, d);
    `CHK(d, 8'h00)
    u_ccc_host.gc(8'h05);
    `CHK(o_alarm_release, 1'b0)
    u_ccc_host.wr(8'h0A, 8'h02);
    u_ccc_host.gc(8'h06);
    `CHK(o_alarm_release, 1'b1)
    u_ccc_host.rd(8'h04, d);
    `CHK(d, 8'h07)
    print_verdict();
  end
endmodule
bind ccc_core ccc_core_props #(.P_CONV_LONG_CYC(P_CONV_LONG_CYC),
  .P_CONV_SHORT_CYC(P_CONV_SHORT_CYC)) u_ccc_core_props (.i_clk, .i_rst_b, .i_wr_stb,
  .i_rd_stb, .i_ptr, .i_wdata, .i_gc_addr_stb, .i_gc_stb, .i_gc_byte, .o_rdata, .o_gc_ack,
  .o_shutdown, .o_conv_start, .o_conv_end, .o_conv_chan, .o_beta_auto, .o_beta_range,
  .o_eta_num, .o_alarm_release);
`default_nettype wire
